// >>> core/fpd_ctrl.sv
// duty front end, standby machine, access gate and protection timers
//
// Function
// - drive pwm at 24.0 kHz, 8-bit duty, nonzero duty never below 2.3 percent
// - integrate speed command into an 8-bit measured duty
// - window 21.3 ms with select 0, 85.3 ms with select 1
// - standby allowed: wake and start when duty exceeds 9.0 percent
// - standby allowed: start standby entry when duty below 7.8 percent two windows in a row
// - in standby always use the fast window
// - entry brakes at zero duty until coil current gone, then tri-state
// - standby entry and exit ignore protection state
// - standby disallowed: never sleep, hold floor speed down to zero duty
// - tach config codes: pulses, div2, mul2, ready high, overcurrent trip, ready low
// - standby allowed, config not 101: programming access unrestricted until the lock is set
// - standby allowed, config 101: access only once in standby
// - standby disallowed, config not 101: access only right after reset
// - standby disallowed with config 101 written: access blocked until the next reset
// - open loop when loop gain select equals 000
// - nv word 5: startup select bits 12..11, ceiling code bits 8..3
// - ceiling is (66 + 3 * code) / 256, full for codes 62 and 63
// - open loop startup duty chosen by startup select
// - open loop drive linear in input duty from 10.2 to 97.7 percent
// - disable bridge after overvoltage persists beyond 80 us
// - extra overvoltage blanking up to 4 ms after supply rise ends
// - overcurrent beyond 0.5 us trips, drive retried after 5 ms
// - programming mode: speed command pin is the serial clock input
// - programming mode: tach pin is the bidirectional serial data line
// - closed loop: input duty sets target between floor and top speed
`timescale 1ns/1ps
module fpd_ctrl (
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   input  wire logic               clk_en_i,
   input  wire fpd_pkg::fpd_cfg_t  cfg_i,
   input  wire fpd_pkg::fpd_sense_t sense_i,
   input  wire logic               speed_command_pin_i,
   input  wire logic               prog_mode_i,
   input  wire logic               cfg_write_i,
   input  wire logic               prog_req_i,
   input  wire logic               tach_pulse_i,
   input  wire logic               tach_data_i,
   input  wire logic               sda_out_i,
   input  wire logic [7:0]         floor_speed_i,
   input  wire logic [7:0]         top_speed_i,
   output logic                    bridge_pwm_o,
   output logic                    bridge_en_o,
   output logic [7:0]              drive_duty_o,
   output logic [7:0]              drive_duty_ceiling_o,
   output logic [7:0]              measured_in_duty_o,
   output logic                    standby_o,
   output logic                    prog_grant_o,
   output logic                    prog_scl_o,
   output logic                    prog_sda_o,
   output logic                    tach_pulse_output_o,
   output logic                    tach_oe_n_o,
   output logic                    open_loop_o,
   output logic [7:0]              target_speed_o,
   output logic                    ov_trip_o,
   output logic                    oc_trip_o
);
   import fpd_pkg::*;

   fpd_state_t state_q;
   logic [7:0] duty_meas;
   logic       win_done;
   logic       low_seen_q;
   logic       startup_q;
   logic       por_window_q;
   logic       locked_q;
   logic       tach_div_q;
   logic       tach_prev_q;
   logic [12:0] pwm_cnt_q;
   logic [12:0] pwm_hi_cyc;
   logic [7:0] pwm_duty_q;
   logic [15:0] ov_cnt_q;
   logic [19:0] blank_cnt_q;
   logic       rising_prev_q;
   logic [5:0] oc_cnt_q;
   logic [19:0] retry_cnt_q;
   logic [5:0] ceil_code;
   logic [1:0] su_sel;
   logic [8:0] ceil_full;
   logic [7:0] ceil_val;
   logic [7:0] lin_duty;
   logic [7:0] run_duty;
   logic [15:0] lin_prod;
   logic       blanking;
   logic       access_ok;
   logic       running;

   // standby always uses the fast window so wake follows one fast window
   fpd_integrator u_int (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .clk_en_i  (clk_en_i),
      .cmd_i     (speed_command_pin_i),
      .slow_i    (cfg_i.slow_window_select && (state_q != FPD_STBY)),
      .duty_o    (duty_meas),
      .done_o    (win_done)
   );

   assign ceil_code = cfg_i.nv_word5[NVW5_CEIL_HI:NVW5_CEIL_LO];
   assign su_sel    = cfg_i.nv_word5[NVW5_SU_HI:NVW5_SU_LO];
   assign ceil_full = CEIL_BASE + 9'(ceil_code) * 9'h003;
   // 100 percent is stored as 8'hff since the counter has 256 slots
   assign ceil_val  = (ceil_code >= 6'h3e || ceil_full >= FULL_DUTY) ? 8'hff
                      : ceil_full[7:0];

   // linear span mapped onto 0..ceiling; floor below the span, ceiling above it
   assign lin_prod = 16'(duty_meas - LIN_LOW) * 16'(ceil_val);
   always_comb begin
      if (duty_meas <= LIN_LOW) begin
         lin_duty = MIN_DRIVE_DUTY;
      end else if (duty_meas >= LIN_HIGH) begin
         lin_duty = ceil_val;
      end else begin
         lin_duty = 8'(lin_prod / 16'(LIN_HIGH - LIN_LOW));
      end
      if (lin_duty > ceil_val) begin
         lin_duty = ceil_val;
      end
   end

   // rising_prev_q covers the edge at which the rise ends and the timer loads
   assign blanking  = (blank_cnt_q != 20'h0) || sense_i.supply_rising || rising_prev_q;
   // ready means running on the regulated duty, past start-up
   assign running   = (state_q == FPD_RUN) && !startup_q;

   always_comb begin
      if (state_q != FPD_RUN || ov_trip_o || oc_trip_o) begin
         run_duty = 8'h00;
      end else if (startup_q) begin
         run_duty = STARTUP_DUTY[su_sel];
      end else begin
         run_duty = lin_duty;
      end
      if (run_duty != 8'h00 && run_duty < MIN_DRIVE_DUTY) begin
         run_duty = MIN_DRIVE_DUTY;
      end
   end

   // standby machine driven by measured duty, standby_allow and coil current
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q    <= FPD_RUN;
         low_seen_q <= 1'b0;
         startup_q  <= 1'b1;
      end else if (clk_en_i) begin
         case (state_q)
            FPD_RUN: begin
               if (win_done) begin
                  startup_q <= 1'b0;
                  if (cfg_i.standby_allow && duty_meas < SLEEP_DUTY_THR) begin
                     // a second low window means low for longer than one window
                     low_seen_q <= 1'b1;
                     if (low_seen_q) begin
                        state_q <= FPD_BRAKE;
                     end
                  end else begin
                     low_seen_q <= 1'b0;
                  end
               end
            end
            FPD_BRAKE: begin
               low_seen_q <= 1'b0;
               if (!sense_i.coil_current) begin
                  state_q <= FPD_STBY;
               end
            end
            FPD_STBY: begin
               if (win_done && (duty_meas > WAKE_DUTY_THR || !cfg_i.standby_allow)) begin
                  state_q   <= FPD_RUN;
                  startup_q <= 1'b1;
               end
            end
            default: begin
               state_q <= FPD_RUN;
            end
         endcase
      end
   end

   // programming access gate
   always_comb begin
      if (cfg_i.standby_allow) begin
         access_ok = (cfg_i.tach_pin_config != TACH_RD_LOW) || (state_q == FPD_STBY);
      end else begin
         access_ok = por_window_q && (cfg_i.tach_pin_config != TACH_RD_LOW);
      end
      if (locked_q) begin
         access_ok = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         por_window_q <= 1'b1;
         locked_q     <= 1'b0;
         prog_grant_o <= 1'b0;
      end else if (clk_en_i) begin
         // the reset window closes once the fan leaves its first start and programming mode is off
         if (!prog_mode_i && !startup_q) begin
            por_window_q <= 1'b0;
         end
         if (cfg_write_i && !cfg_i.standby_allow && cfg_i.tach_pin_config == TACH_RD_LOW) begin
            locked_q <= 1'b1;
         end
         prog_grant_o <= prog_req_i && access_ok;
      end
   end

   // tach edge tracking for the divide and multiply modes
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tach_div_q  <= 1'b0;
         tach_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         tach_prev_q <= tach_pulse_i;
         if (tach_pulse_i && !tach_prev_q) begin
            tach_div_q <= ~tach_div_q;
         end
      end
   end

   // serial clock from command pin, data on tach pin; oe low drives the pin
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_scl_o          <= 1'b1;
         prog_sda_o          <= 1'b1;
         tach_pulse_output_o <= 1'b0;
         tach_oe_n_o         <= 1'b1;
      end else if (clk_en_i) begin
         if (prog_mode_i && access_ok) begin
            prog_scl_o          <= speed_command_pin_i;
            prog_sda_o          <= tach_data_i;
            tach_pulse_output_o <= 1'b0;
            tach_oe_n_o         <= sda_out_i;
         end else begin
            tach_oe_n_o <= 1'b0;
            case (cfg_i.tach_pin_config)
               3'h0: tach_pulse_output_o <= tach_pulse_i;
               3'h1: tach_pulse_output_o <= tach_div_q;
               3'h7: tach_pulse_output_o <= tach_pulse_i ^ tach_prev_q;
               // the ready codes name the level shown before the fan is ready
               3'h4: tach_pulse_output_o <= !running;
               3'h5: tach_pulse_output_o <= running;
               3'h3: tach_pulse_output_o <= oc_trip_o;
               default: tach_pulse_output_o <= tach_pulse_i;
            endcase
         end
      end
   end

   // high time in cycles; 8'hff is forced on since 256 slots fall short of a period
   assign pwm_hi_cyc = 13'(pwm_duty_q) * 13'(SLOT_CYC);

   // carrier counter, duty latched at each period start
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pwm_cnt_q    <= 13'h0;
         pwm_duty_q   <= 8'h0;
         bridge_pwm_o <= 1'b0;
      end else if (clk_en_i) begin
         if (pwm_cnt_q >= 13'(CARRIER_CYC - 1)) begin
            pwm_cnt_q  <= 13'h0;
            pwm_duty_q <= run_duty;
         end else begin
            pwm_cnt_q <= pwm_cnt_q + 13'h1;
         end
         bridge_pwm_o <= (pwm_duty_q == 8'hff) || (pwm_cnt_q < pwm_hi_cyc);
      end
   end

   // overvoltage debounce and blanking
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ov_cnt_q      <= 16'h0;
         blank_cnt_q   <= 20'h0;
         rising_prev_q <= 1'b0;
         ov_trip_o     <= 1'b0;
      end else if (clk_en_i) begin
         rising_prev_q <= sense_i.supply_rising;
         if (rising_prev_q && !sense_i.supply_rising) begin
            blank_cnt_q <= 20'(OV_BLANK_CYC);
         end else if (blank_cnt_q != 20'h0) begin
            blank_cnt_q <= blank_cnt_q - 20'h1;
         end
         if (!sense_i.ov_raw || blanking) begin
            ov_cnt_q  <= 16'h0;
            ov_trip_o <= 1'b0;
         end else if (ov_cnt_q >= 16'(OV_DEB_CYC)) begin
            ov_trip_o <= 1'b1;
         end else begin
            ov_cnt_q <= ov_cnt_q + 16'h1;
         end
      end
   end

   // overcurrent debounce, then a fixed wait before the drive is retried
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         oc_cnt_q    <= 6'h0;
         retry_cnt_q <= 20'h0;
         oc_trip_o   <= 1'b0;
      end else if (clk_en_i) begin
         if (oc_trip_o) begin
            oc_cnt_q <= 6'h0;
            if (retry_cnt_q == 20'h0) begin
               oc_trip_o <= 1'b0;
            end else begin
               retry_cnt_q <= retry_cnt_q - 20'h1;
            end
         end else if (!sense_i.oc_raw) begin
            oc_cnt_q <= 6'h0;
         end else if (oc_cnt_q >= 6'(OC_DEB_CYC)) begin
            oc_trip_o   <= 1'b1;
            retry_cnt_q <= 20'(OC_RETRY_CYC - 1);
         end else begin
            oc_cnt_q <= oc_cnt_q + 6'h1;
         end
      end
   end

   // registered status outputs
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bridge_en_o          <= 1'b0;
         drive_duty_o         <= 8'h0;
         drive_duty_ceiling_o <= 8'h0;
         measured_in_duty_o   <= 8'h0;
         standby_o            <= 1'b0;
         open_loop_o          <= 1'b0;
         target_speed_o       <= 8'h0;
      end else if (clk_en_i) begin
         bridge_en_o          <= (state_q != FPD_STBY) && !ov_trip_o && !oc_trip_o;
         drive_duty_o         <= run_duty;
         drive_duty_ceiling_o <= ceil_val;
         measured_in_duty_o   <= duty_meas;
         standby_o            <= (state_q == FPD_STBY);
         open_loop_o          <= (cfg_i.loop_gain_select == OPEN_LOOP_GAIN);
         target_speed_o       <= floor_speed_i +
            8'((16'(top_speed_i - floor_speed_i) * 16'(duty_meas)) >> 8);
      end
   end
endmodule

// >>> core/fpd_integrator.sv
// speed-command integrator producing the 8-bit measured duty
`timescale 1ns/1ps
module fpd_integrator (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   input  wire logic       clk_en_i,
   input  wire logic       cmd_i,
   input  wire logic       slow_i,
   output logic [7:0]      duty_o,
   output logic            done_o
);
   import fpd_pkg::*;
   logic [23:0] cnt_q;
   logic [23:0] hi_q;
   logic [23:0] win;
   assign win = slow_i ? 24'(SLOW_WIN_CYC) : 24'(FAST_WIN_CYC);
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q  <= 24'h0;
         hi_q   <= 24'h0;
         duty_o <= 8'h0;
         done_o <= 1'b0;
      end else if (clk_en_i) begin
         done_o <= 1'b0;
         if (cnt_q >= win - 24'h1) begin
            // fraction of high samples scaled to 8 bits
            duty_o <= 8'(({8'h0, hi_q} * 32'd255) / {8'h0, win});
            cnt_q  <= 24'h0;
            hi_q   <= 24'h0;
            done_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 24'h1;
            hi_q  <= hi_q + {23'h0, cmd_i};
         end
      end
   end
endmodule

// >>> core/fpd_pkg.sv
// constants and carrier types of the fan duty and standby controller
package fpd_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   // carrier 24.0 kHz
   localparam int unsigned CARRIER_HZ      = 24_000;
   localparam int unsigned CARRIER_CYC     = CLK_HZ / CARRIER_HZ;
   localparam int unsigned SLOT_CYC        = CARRIER_CYC / 256;
   localparam int unsigned FAST_WIN_US     = 21_300;
   localparam int unsigned SLOW_WIN_US     = 85_300;
   localparam int unsigned FAST_WIN_CYC    = FAST_WIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SLOW_WIN_CYC    = SLOW_WIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned OV_DEB_NS       = 80_000;
   localparam int unsigned OV_DEB_CYC      = OV_DEB_NS / 10;
   localparam int unsigned OV_BLANK_US     = 4_000;
   localparam int unsigned OV_BLANK_CYC    = OV_BLANK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned OC_DEB_NS       = 500;
   localparam int unsigned OC_DEB_CYC      = (OC_DEB_NS + 9) / 10;
   localparam int unsigned OC_RETRY_US     = 5_000;
   localparam int unsigned OC_RETRY_CYC    = OC_RETRY_US * (CLK_HZ / 1_000_000);
   // 9.0 %, 7.8 %, 2.3 %, 10.2 %, 97.7 % of 256
   localparam logic [7:0]  WAKE_DUTY_THR   = 8'h17;
   localparam logic [7:0]  SLEEP_DUTY_THR  = 8'h14;
   localparam logic [7:0]  MIN_DRIVE_DUTY  = 8'h06;
   localparam logic [7:0]  LIN_LOW         = 8'h1a;
   localparam logic [7:0]  LIN_HIGH        = 8'hfa;
   localparam logic [8:0]  CEIL_BASE       = 9'h042;
   localparam logic [8:0]  FULL_DUTY       = 9'h100;
   localparam logic [2:0]  TACH_RD_LOW     = 3'h5;
   localparam logic [2:0]  OPEN_LOOP_GAIN  = 3'h0;
   localparam int unsigned NVW5_SU_HI      = 12;
   localparam int unsigned NVW5_SU_LO      = 11;
   localparam int unsigned NVW5_CEIL_HI    = 8;
   localparam int unsigned NVW5_CEIL_LO    = 3;
   localparam logic [7:0]  STARTUP_DUTY [4] = '{8'h40, 8'h80, 8'hc0, 8'hff};
   typedef enum logic [1:0] {
      FPD_RUN   = 2'b00,
      FPD_BRAKE = 2'b01,
      FPD_STBY  = 2'b10
   } fpd_state_t;
   typedef struct packed {
      logic       standby_allow;
      logic [2:0] tach_pin_config;
      logic       slow_window_select;
      logic [2:0] loop_gain_select;
      logic [15:0] nv_word5;
   } fpd_cfg_t;
   typedef struct packed {
      logic ov_raw;
      logic oc_raw;
      logic supply_rising;
      logic coil_current;
   } fpd_sense_t;
endpackage

// >>> sim/fpd_ctrl_properties.sv
// port-level assertions for the fan duty and standby controller
`timescale 1ns/1ps
module fpd_ctrl_properties (
   input wire logic                ref_clk_i,
   input wire logic                reset_i,
   input wire fpd_pkg::fpd_cfg_t   cfg_i,
   input wire fpd_pkg::fpd_sense_t sense_i,
   input wire logic                speed_command_pin_i,
   input wire logic                prog_mode_i,
   input wire logic                cfg_write_i,
   input wire logic                prog_req_i,
   input wire logic                sda_out_i,
   input wire logic                bridge_en_o,
   input wire logic [7:0]          drive_duty_o,
   input wire logic [7:0]          drive_duty_ceiling_o,
   input wire logic                standby_o,
   input wire logic                prog_grant_o,
   input wire logic                prog_scl_o,
   input wire logic                tach_oe_n_o,
   input wire logic                open_loop_o,
   input wire logic                ov_trip_o,
   input wire logic                oc_trip_o
);
   import fpd_pkg::*;
   logic [2:0]  up_q;
   logic        lock_q;
   logic [6:0]  oc_q;
   logic [13:0] ov_q;
   // settle count keeps checks off the reset-release edges
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         up_q   <= 3'h0;
         lock_q <= 1'b0;
      end else begin
         up_q   <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
         lock_q <= lock_q | (cfg_write_i & ~cfg_i.standby_allow
                   & (cfg_i.tach_pin_config == TACH_RD_LOW));
      end
   end
   // run lengths of the raw fault inputs
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         oc_q <= 7'h00;
         ov_q <= 14'h0000;
      end else begin
         oc_q <= !sense_i.oc_raw ? 7'h00 : (oc_q == 7'h7f) ? oc_q : oc_q + 7'h01;
         ov_q <= !sense_i.ov_raw ? 14'h0000 : (ov_q == 14'h3fff) ? ov_q : ov_q + 14'h0001;
      end
   end
   function automatic logic [7:0] ceil_f(input logic [5:0] c);
      logic [8:0] v;
      v = 9'h042 + 9'(c) * 9'h003;
      return (c >= 6'h3e) ? 8'hff : v[7:0];
   endfunction
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   ceil_map_a: assert property (
      (up_q == 3'h7 && $stable(cfg_i))[*3] |-> drive_duty_ceiling_o == ceil_f(cfg_i.nv_word5[8:3]))
      else $error("ceiling off");
   grant_open_a: assert property (
      (up_q == 3'h7 && cfg_i.standby_allow && cfg_i.tach_pin_config != TACH_RD_LOW && !lock_q
      && $stable(cfg_i))[*2] ##0 prog_req_i |=> prog_grant_o) else $error("access refused");
   grant_warm_a: assert property (
      (cfg_i.standby_allow && cfg_i.tach_pin_config == TACH_RD_LOW && !standby_o)[*2]
      |=> !prog_grant_o || standby_o) else $error("access before standby");
   lock_hold_a: assert property (lock_q[*2] |=> !prog_grant_o)
      else $error("access after lock");
   oc_debounce_a: assert property ($rose(oc_trip_o) |-> oc_q >= 7'h32)
      else $error("overcurrent trip too early");
   ov_debounce_a: assert property ($rose(ov_trip_o) |-> ov_q >= 14'h1f40)
      else $error("overvoltage trip too early");
   trip_bridge_off_a: assert property ((oc_trip_o || ov_trip_o)[*2] |-> !bridge_en_o)
      else $error("bridge on while tripped");
   duty_floor_a: assert property (drive_duty_o != 8'h00 |-> drive_duty_o >= MIN_DRIVE_DUTY)
      else $error("drive duty below floor");
   scl_copy_a: assert property (
      (prog_mode_i && $stable(speed_command_pin_i))[*3] |-> prog_scl_o == speed_command_pin_i)
      else $error("serial clock not passed");
   oe_copy_a: assert property (
      (prog_mode_i && $stable(sda_out_i))[*3] |-> tach_oe_n_o == sda_out_i)
      else $error("data enable wrong");
   open_loop_a: assert property (
      (up_q == 3'h7 && $stable(cfg_i.loop_gain_select))[*2]
      |-> open_loop_o == (cfg_i.loop_gain_select == OPEN_LOOP_GAIN)) else $error("loop mode");
   cover property (prog_grant_o);
   cover property ($rose(oc_trip_o));
   cover property ($rose(ov_trip_o));
endmodule

// >>> sim/fpd_host_model.sv
// host model driving the speed-command pin
`timescale 1ns/1ps
module fpd_host_model (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [15:0] high_cyc_i,
   input  wire logic [15:0] period_cyc_i,
   output logic             pin_o
);
   logic [15:0] cnt_q;
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= (cnt_q + 16'h0001 >= period_cyc_i) ? 16'h0000 : cnt_q + 16'h0001;
      end
   end
   // period 0 parks the pin high, as the pin pull-up would; also the serial clock
   assign pin_o = (period_cyc_i == 16'h0000) ? 1'b1 : (cnt_q < high_cyc_i);
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the fan duty and standby controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module tb_top;
   import fpd_pkg::*;
   logic        ref_clk_i, reset_i, speed_command_pin_i, prog_mode_i, cfg_write_i;
   logic        prog_req_i, sda_out_i, host_sda, tach_pls;
   wire         tach_data_i;
   fpd_cfg_t    cfg_i;
   fpd_sense_t  sense_i;
   logic        bridge_pwm_o, bridge_en_o, standby_o, prog_grant_o, prog_scl_o, prog_sda_o;
   logic        tach_pulse_output_o, tach_oe_n_o, open_loop_o, ov_trip_o, oc_trip_o;
   logic [7:0]  drive_duty_o, drive_duty_ceiling_o, measured_in_duty_o, target_speed_o;
   logic [15:0] hi_cyc, per_cyc;
   logic [7:0]  su_tab [4] = '{8'h40, 8'h80, 8'hc0, 8'hff};
   logic [2:0]  tcodes [5] = '{3'h0, 3'h1, 3'h7, 3'h4, 3'h3};
   logic [4:0]  t_exp = 5'b01011;
   int          n_fail = 0;
   int          checked = 0;
   int          hi_n, lo_n;
   // open-drain data wire: low whenever the device pulls
   assign tach_data_i = host_sda & tach_oe_n_o;
   fpd_ctrl dut (
      .ref_clk_i, .reset_i, .clk_en_i(1'b1), .cfg_i, .sense_i, .speed_command_pin_i,
      .prog_mode_i, .cfg_write_i, .prog_req_i, .tach_pulse_i(tach_pls), .tach_data_i, .sda_out_i,
      .floor_speed_i(8'h20), .top_speed_i(8'hf0), .bridge_pwm_o, .bridge_en_o, .drive_duty_o,
      .drive_duty_ceiling_o, .measured_in_duty_o, .standby_o, .prog_grant_o, .prog_scl_o,
      .prog_sda_o, .tach_pulse_output_o, .tach_oe_n_o, .open_loop_o, .target_speed_o,
      .ov_trip_o, .oc_trip_o
   );
   fpd_host_model u_host (
      .ref_clk_i, .reset_i, .high_cyc_i(hi_cyc), .period_cyc_i(per_cyc),
      .pin_o(speed_command_pin_i)
   );
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic do_reset();
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
   endtask
   task automatic stop_test();
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic access(input logic exp_g);
      prog_req_i = 1'b1;
      tick(3);
      `CHK("grant", exp_g, prog_grant_o);
      prog_req_i = 1'b0;
      tick(2);
   endtask
   // bounded wait for a pwm level, returning the cycles spent
   task automatic wait_pwm(input logic lvl, output int k);
      k = 0;
      while (bridge_pwm_o !== lvl && k < 9000) begin
         tick(1);
         k++;
      end
      if (k >= 9000) begin
         n_fail++;
         stop_test();
      end
   endtask
   initial begin
      cfg_i = '0;
      cfg_i.standby_allow = 1'b1;
      cfg_i.nv_word5 = 16'h01f8;
      sense_i = '0;
      {prog_mode_i, cfg_write_i, prog_req_i} = 3'h0;
      {host_sda, sda_out_i, tach_pls} = 3'h6;
      hi_cyc = 16'h0000;
      per_cyc = 16'h0000;
      reset_i = 1'b1;
      tick(1);
      `CHK("reset scl", 1'b1, prog_scl_o);
      `CHK("reset oe", 1'b1, tach_oe_n_o);
      for (int s = 0; s < 4; s++) begin
         cfg_i.nv_word5[12:11] = 2'(s);
         do_reset();
         tick(4);
         `CHK("startup duty", su_tab[s], drive_duty_o);
      end
      cfg_i.nv_word5[12:11] = 2'h0;
      do_reset();
      tick(4);
      `CHK("bridge on", 1'b1, bridge_en_o);
      `CHK("awake", 1'b0, standby_o);
      `CHK("duty in", 8'h00, measured_in_duty_o);
      `CHK("target", 8'h20, target_speed_o);
      wait_pwm(1'b0, hi_n);
      wait_pwm(1'b1, hi_n);
      wait_pwm(1'b0, hi_n);
      wait_pwm(1'b1, lo_n);
      `CHK("pwm high", SLOT_CYC * 64, hi_n);
      `CHK("pwm period", CARRIER_CYC, hi_n + lo_n);
      for (int c = 0; c < 64; c++) begin
         cfg_i.nv_word5[8:3] = 6'(c);
         tick(4);
         `CHK("ceiling", (c >= 62) ? 8'hff : 8'(66 + 3 * c), drive_duty_ceiling_o);
      end
      for (int g = 0; g < 8; g++) begin
         cfg_i.loop_gain_select = 3'(g);
         tick(3);
         `CHK("open loop", g == 0, open_loop_o);
      end
      foreach (tcodes[i]) begin
         cfg_i.tach_pin_config = tcodes[i];
         access(1'b1);
      end
      cfg_i.tach_pin_config = TACH_RD_LOW;
      access(1'b0);
      cfg_i.standby_allow = 1'b0;
      cfg_i.tach_pin_config = 3'h0;
      access(1'b1);
      cfg_i.tach_pin_config = TACH_RD_LOW;
      cfg_write_i = 1'b1;
      tick(1);
      cfg_write_i = 1'b0;
      access(1'b0);
      cfg_i.standby_allow = 1'b1;
      cfg_i.tach_pin_config = 3'h0;
      access(1'b0);
      tach_pls = 1'b1;
      foreach (tcodes[i]) begin
         cfg_i.tach_pin_config = tcodes[i];
         tick(2);
         `CHK("tach pin", t_exp[i], tach_pulse_output_o);
      end
      cfg_i.tach_pin_config = TACH_RD_LOW;
      tick(2);
      `CHK("ready low", 1'b0, tach_pulse_output_o);
      cfg_i.tach_pin_config = 3'h0;
      do_reset();
      prog_mode_i = 1'b1;
      for (int v = 0; v < 2; v++) begin
         per_cyc = (v == 0) ? 16'h0001 : 16'h0000;
         host_sda = 1'(v);
         sda_out_i = 1'(v);
         tick(4);
         `CHK("scl copy", 1'(v), prog_scl_o);
         `CHK("oe copy", 1'(v), tach_oe_n_o);
         `CHK("sda copy", 1'(v), prog_sda_o);
      end
      prog_mode_i = 1'b0;
      do_reset();
      sense_i.oc_raw = 1'b1;
      tick(45);
      `CHK("oc early", 1'b0, oc_trip_o);
      tick(15);
      `CHK("oc trip", 1'b1, oc_trip_o);
      tick(2);
      `CHK("oc bridge", 1'b0, bridge_en_o);
      sense_i.oc_raw = 1'b0;
      do_reset();
      sense_i.supply_rising = 1'b1;
      tick(5);
      sense_i.supply_rising = 1'b0;
      sense_i.ov_raw = 1'b1;
      tick(9000);
      `CHK("ov blanked", 1'b0, ov_trip_o);
      sense_i.ov_raw = 1'b0;
      do_reset();
      sense_i.ov_raw = 1'b1;
      tick(7990);
      `CHK("ov early", 1'b0, ov_trip_o);
      tick(30);
      `CHK("ov trip", 1'b1, ov_trip_o);
      `CHK("ov bridge", 1'b0, bridge_en_o);
      sense_i.ov_raw = 1'b0;
      stop_test();
   end
endmodule
bind fpd_ctrl fpd_ctrl_properties u_props (
   .ref_clk_i, .reset_i, .cfg_i, .sense_i, .speed_command_pin_i, .prog_mode_i, .cfg_write_i,
   .prog_req_i, .sda_out_i, .bridge_en_o, .drive_duty_o, .drive_duty_ceiling_o, .standby_o,
   .prog_grant_o, .prog_scl_o, .tach_oe_n_o, .open_loop_o, .ov_trip_o, .oc_trip_o
);
